// ==== sssw_defs.vh ====
// constants for the supply supervision / stop-mode watchdog block
// assumes an apb slave with 32-bit data and a 20 mhz clock
`ifndef SSSW_DEFS_VH
`define SSSW_DEFS_VH

// ****************
// register offsets
// ****************
`define SSSW_OFF_MODE 12'h000
`define SSSW_OFF_WDCTRL 12'h004
`define SSSW_OFF_WAKE 12'h008
`define SSSW_OFF_FLAGS 12'h00c
`define SSSW_OFF_CFG 12'h010
`define SSSW_OFF_STAT 12'h014

// ****************
// mode encodings (mode register field)
// ****************
`define SSSW_CMD_NORMAL 2'h0
`define SSSW_CMD_SLEEP 2'h1
`define SSSW_CMD_STOP 2'h2
`define SSSW_CMD_SOFTRST 2'h3

// ****************
// field positions
// ****************
`define SSSW_WD_ARM_HI_BIT 4
`define SSSW_WAKE_ARM_LO_BIT 0
`define SSSW_WAKE_BUSWD_BIT 1
`define SSSW_CFG_AUXKEEP_BIT 0
`define SSSW_CFG_OVRST_BIT 1
`define SSSW_FLAGS_W 11
`define SSSW_FL_POR 0
`define SSSW_FL_VSUV 1
`define SSSW_FL_SWUV 2
`define SSSW_FL_SWOV 3
`define SSSW_FL_WARN 4
`define SSSW_FL_UV 5
`define SSSW_FL_UVFS 6
`define SSSW_FL_OV 7
`define SSSW_FL_SC 8
`define SSSW_FL_V2UV 9
`define SSSW_FL_CANUV 10

// ****************
// reset values
// ****************
`define SSSW_WDCTRL_RST 8'h00
`define SSSW_WAKE_RST 8'h02
`define SSSW_CFG_RST 8'h00

// ****************
// timing
// ****************
`define SSSW_CLK_KHZ 20000
`define SSSW_TRD_US 10000
`define SSSW_TSC_MS 4
`define SSSW_TLW_MS 200
`define SSSW_UV_FS_COUNT 4

`endif

// ==== sssw_supervisor.v ====
// supply supervision, mode control and stop-mode watchdog disable logic
// assumes comparator inputs are synchronous levels; apb master per amba
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sssw_defs.vh"

module sssw_supervisor #(
	parameter RD_CYCLES = (`SSSW_TRD_US * (`SSSW_CLK_KHZ / 1000)),
	parameter SC_CYCLES = (`SSSW_TSC_MS * `SSSW_CLK_KHZ),
	parameter LW_CYCLES = (`SSSW_TLW_MS * `SSSW_CLK_KHZ)
) (
	input wire clk, // 20 mhz clock
	input wire rst, // async reset, main supply power-on
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error
	input wire vs_low_in, // main supply undervoltage comparator
	input wire vs_por_low_in, // main supply below falling por threshold
	input wire sw_low_in, // switch supply undervoltage
	input wire sw_high_in, // switch supply overvoltage
	input wire mcu_warn_in, // mcu supply prewarning
	input wire mcu_low_in, // mcu supply below reset threshold
	input wire mcu_high_in, // mcu supply overvoltage
	input wire v2_low_in, // second regulator undervoltage
	input wire v2_ramp_in, // second regulator turning on or off
	input wire can_low_in, // transceiver supply undervoltage
	input wire can_wake_in, // can wake level
	input wire wd_trigger_in, // valid watchdog service pulse
	input wire wd_seq_err_in, // disable-sequence error pulse
	input wire fail_config_select, // strap level
	output reg reset_output_n, // reset output, low active
	output reg fail_outputs, // fail outputs active
	output reg mcu_supply_on, // mcu regulator enable
	output reg aux_reg_on, // auxiliary regulator enable
	output reg sc_prot_on, // mcu short protection active
	output reg wake_irq, // wake interrupt pulse
	output reg can_rxd_low, // force can rxd low
	output reg wd_active, // watchdog running
	output reg wd_long_window, // watchdog in long open window
	output reg [2:0] mode_state // current mode code
);

	localparam [5:0] ST_INIT = 6'h01;
	localparam [5:0] ST_NORMAL = 6'h02;
	localparam [5:0] ST_STOP = 6'h04;
	localparam [5:0] ST_RESTART = 6'h08;
	localparam [5:0] ST_FAILSAFE = 6'h10;
	localparam [5:0] ST_SLEEP = 6'h20;

	// ****************
	// comparator synchronisers
	// ****************
	localparam NIN = 13;
	reg [NIN-1:0] s1_reg, s2_reg, s3_reg;
	wire [NIN-1:0] raw = {can_wake_in, can_low_in, v2_ramp_in, v2_low_in, mcu_high_in,
		mcu_low_in, mcu_warn_in, sw_high_in, sw_low_in, vs_por_low_in, vs_low_in,
		wd_trigger_in, wd_seq_err_in};
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= {NIN{1'b0}};
			s2_reg <= {NIN{1'b0}};
			s3_reg <= {NIN{1'b0}};
		end else begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	wire [NIN-1:0] rise = s2_reg & ~s3_reg;
	wire seq_err = rise[0];
	wire wd_trig = rise[1];
	wire vs_low = s2_reg[2];
	wire vs_por = s2_reg[3];
	wire mcu_low = s2_reg[7];
	wire mcu_low_rise = rise[7];
	wire mcu_high_rise = rise[8];
	wire can_wake = rise[12];

	// ****************
	// state and registers
	// ****************
	reg [5:0] st_reg, st_next;
	reg [7:0] wdctrl_reg, wake_reg, cfg_reg;
	reg [`SSSW_FLAGS_W-1:0] flags_reg;
	reg [2:0] uvcnt_reg;
	reg [31:0] tmr_reg, sc_reg, lw_reg;
	reg off_reg, por_done_reg;

	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire in_normal = st_reg[1];
	wire in_stop = st_reg[2];
	wire uv_active = st_reg[0] | in_normal | in_stop;
	wire arm_lo = wake_reg[`SSSW_WAKE_ARM_LO_BIT];
	wire arm_hi = wdctrl_reg[`SSSW_WD_ARM_HI_BIT];
	wire wd_off_stop = in_stop & arm_lo & arm_hi;

	function hit;
		input [11:0] a;
		input [11:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	wire w_mode = wr & hit(paddr, `SSSW_OFF_MODE);
	wire w_wd = wr & hit(paddr, `SSSW_OFF_WDCTRL);
	wire w_wake = wr & hit(paddr, `SSSW_OFF_WAKE);
	wire w_flags = wr & hit(paddr, `SSSW_OFF_FLAGS);
	wire w_cfg = wr & hit(paddr, `SSSW_OFF_CFG);
	wire [1:0] cmd = pwdata[1:0];
	wire soft_rst = w_mode & (in_normal | in_stop) & (cmd == `SSSW_CMD_SOFTRST);
	wire go_normal = w_mode & (in_normal | in_stop) & (cmd == `SSSW_CMD_NORMAL);
	// sequence begins with a write that sets the high arm bit in normal mode
	wire seq_start = w_wd & in_normal & pwdata[`SSSW_WD_ARM_HI_BIT] & ~arm_hi;
	wire wd_restart = (in_stop & wd_off_stop & wd_trig) | go_normal |
		(in_stop & can_wake & wake_reg[`SSSW_WAKE_BUSWD_BIT]);
	wire sc_fault = ~vs_low & mcu_low & (sc_reg >= SC_CYCLES - 1);
	wire ov_act = mcu_high_rise & uv_active & cfg_reg[`SSSW_CFG_OVRST_BIT];
	wire uv_event = mcu_low_rise & uv_active;
	wire uv_fs = uv_event & ~(in_normal & vs_low) &
		(uvcnt_reg == `SSSW_UV_FS_COUNT - 1);

	// ****************
	// mode state machine
	// ****************
	always @* begin
		st_next = st_reg;
		case (st_reg)
			ST_INIT, ST_NORMAL, ST_STOP: begin
				if (sc_fault || uv_fs || (ov_act && !fail_config_select))
					st_next = ST_FAILSAFE;
				else if (uv_event || ov_act)
					st_next = ST_RESTART;
				else if (soft_rst)
					st_next = ST_INIT;
				else if (w_mode && st_reg != ST_INIT && cmd == `SSSW_CMD_STOP)
					st_next = ST_STOP;
				else if (w_mode && cmd == `SSSW_CMD_SLEEP)
					st_next = ST_SLEEP;
				else if (go_normal || (w_mode && st_reg == ST_INIT && cmd == `SSSW_CMD_NORMAL))
					st_next = ST_NORMAL;
			end
			ST_RESTART: begin
				// leaves after the delay even if overvoltage remains
				if (tmr_reg >= RD_CYCLES - 1 && !mcu_low)
					st_next = ST_NORMAL;
			end
			ST_FAILSAFE: begin
				if (can_wake)
					st_next = ST_RESTART;
			end
			ST_SLEEP: begin
				if (can_wake)
					st_next = ST_RESTART;
			end
			default: st_next = ST_INIT;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= ST_INIT;
			wdctrl_reg <= `SSSW_WDCTRL_RST;
			wake_reg <= `SSSW_WAKE_RST;
			cfg_reg <= `SSSW_CFG_RST;
			flags_reg <= {`SSSW_FLAGS_W{1'b0}};
			uvcnt_reg <= 3'h0;
			tmr_reg <= 32'h0;
			sc_reg <= 32'h0;
			lw_reg <= 32'h0;
			off_reg <= 1'b0;
			por_done_reg <= 1'b0;
		end else if (vs_por) begin
			// main supply gone: these registers back to power-on state, except off_reg, which is set to 1
			st_reg <= ST_INIT;
			wdctrl_reg <= `SSSW_WDCTRL_RST;
			wake_reg <= `SSSW_WAKE_RST;
			cfg_reg <= `SSSW_CFG_RST;
			flags_reg <= {`SSSW_FLAGS_W{1'b0}};
			uvcnt_reg <= 3'h0;
			tmr_reg <= 32'h0;
			sc_reg <= 32'h0;
			lw_reg <= 32'h0;
			off_reg <= 1'b1;
			por_done_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			off_reg <= 1'b0;
			por_done_reg <= 1'b1;
			tmr_reg <= (st_next != st_reg || mcu_low) ? 32'h0 : tmr_reg + 32'h1;
			sc_reg <= (mcu_low && !vs_low && !st_reg[4] && !st_reg[5]) ? sc_reg + 32'h1 : 32'h0;
			if (wd_restart || st_next == ST_NORMAL && st_reg != ST_NORMAL)
				lw_reg <= LW_CYCLES;
			else if (lw_reg != 32'h0)
				lw_reg <= lw_reg - 32'h1;
			if (soft_rst) begin
				wdctrl_reg <= `SSSW_WDCTRL_RST;
				wake_reg <= `SSSW_WAKE_RST;
				cfg_reg <= `SSSW_CFG_RST;
			end else begin
				if (w_wd && in_normal)
					wdctrl_reg <= pwdata[7:0];
				if (w_wake && in_normal)
					wake_reg <= pwdata[7:0];
				if (seq_start && arm_lo)
					wake_reg[`SSSW_WAKE_ARM_LO_BIT] <= 1'b0;
				if (seq_err)
					wdctrl_reg[`SSSW_WD_ARM_HI_BIT] <= 1'b0;
				if (wd_restart) begin
					wdctrl_reg[`SSSW_WD_ARM_HI_BIT] <= 1'b0;
					wake_reg[`SSSW_WAKE_ARM_LO_BIT] <= 1'b0;
				end
				if (w_cfg)
					cfg_reg <= pwdata[7:0];
				if (ov_act && fail_config_select)
					cfg_reg[`SSSW_CFG_OVRST_BIT] <= 1'b0;
			end
			// flag clear: write one clears, set wins, level-held flags resist
			flags_reg <= (flags_reg & ~(w_flags ? pwdata[`SSSW_FLAGS_W-1:0] &
				~{1'b0, 1'b0, 6'h0, s2_reg[5], s2_reg[4], 1'b0} &
				~{9'h0, vs_low, 1'b0} : {`SSSW_FLAGS_W{1'b0}})) |
				{s2_reg[11],
				s2_reg[9] & ~s2_reg[10] ? 1'b1 : 1'b0,
				sc_fault,
				mcu_high_rise & uv_active,
				uv_fs,
				uv_event & !st_reg[5],
				rise[6] & !st_reg[5],
				s2_reg[5], s2_reg[4],
				vs_low,
				~por_done_reg};
			if (uv_fs || st_next == ST_FAILSAFE || soft_rst ||
					(w_flags && pwdata[`SSSW_FL_UV] && !uv_event))
				uvcnt_reg <= 3'h0;
			else if (uv_event && !(in_normal && vs_low))
				uvcnt_reg <= uvcnt_reg + 3'h1;
		end
	end

	// ****************
	// outputs and apb slave
	// ****************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			reset_output_n <= 1'b0;
			fail_outputs <= 1'b0;
			mcu_supply_on <= 1'b0;
			aux_reg_on <= 1'b0;
			sc_prot_on <= 1'b0;
			wake_irq <= 1'b0;
			can_rxd_low <= 1'b0;
			wd_active <= 1'b0;
			wd_long_window <= 1'b0;
			mode_state <= 3'h0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// released only when supply is good and delay served
			reset_output_n <= !off_reg && !mcu_low && !st_next[4] && !st_next[5] &&
				!(st_next[3] || (st_next[0] && tmr_reg < RD_CYCLES - 1));
			if (st_next[4] || ov_act)
				fail_outputs <= 1'b1;
			else if (st_next[1])
				fail_outputs <= 1'b0;
			mcu_supply_on <= !vs_por && !sc_fault && !st_next[4] && !st_next[5];
			aux_reg_on <= !vs_low || cfg_reg[`SSSW_CFG_AUXKEEP_BIT];
			sc_prot_on <= !vs_low;
			wake_irq <= can_wake && in_stop;
			if (can_wake && in_stop)
				can_rxd_low <= 1'b1;
			else if (w_flags || !in_stop)
				can_rxd_low <= 1'b0;
			wd_active <= (st_next[0] || st_next[1] || st_next[2]) &&
				!(st_next[2] && wd_off_stop && !wd_restart);
			wd_long_window <= (lw_reg > 32'h1) || wd_restart;
			mode_state <= st_next[1] ? 3'h1 : st_next[2] ? 3'h2 : st_next[3] ? 3'h3 :
				st_next[4] ? 3'h4 : st_next[5] ? 3'h5 : 3'h0;
			pready <= psel && !pready;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !pready) begin
				case (paddr)
					`SSSW_OFF_MODE: prdata <= {29'h0, mode_state};
					`SSSW_OFF_WDCTRL: prdata <= {24'h0, wdctrl_reg};
					`SSSW_OFF_WAKE: prdata <= {24'h0, wake_reg};
					`SSSW_OFF_FLAGS: prdata <= {21'h0, flags_reg};
					`SSSW_OFF_CFG: prdata <= {24'h0, cfg_reg};
					`SSSW_OFF_STAT: prdata <= {29'h0, uvcnt_reg};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ==== sssw_props_properties.sv ====
// checker for the supervisor apb answer and supply reactions
// assumes bind into sssw_supervisor; inputs reach logic via two flops
`timescale 1ns/1ps
`default_nettype none
module sssw_props (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic vs_low_in, // main low
	input wire logic vs_por_low_in, // main off
	input wire logic mcu_low_in, // mcu low
	input wire logic can_wake_in, // wake
	input wire logic wd_trigger_in, // service
	input wire logic reset_output_n, // reset out
	input wire logic sc_prot_on, // short prot
	input wire logic wake_irq, // wake pulse
	input wire logic can_rxd_low, // rxd low
	input wire logic wd_active, // wd on
	input wire logic wd_long_window, // long window
	input wire logic [2:0] mode_state // mode
);
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
AST_READY: assert property (psel && !penable |=> pready) else $error("no ready");
AST_PULSE: assert property (pready |=> !pready) else $error("ready too long");
AST_SLVERR: assert property (pslverr |-> pready) else $error("error without ready");
AST_RO_REL: assert property ($rose(reset_output_n) |-> !$past(mcu_low_in, 4))
	else $error("reset released early");
AST_RO_UV: assert property ($rose(mcu_low_in) && mode_state == 3'h1 && !vs_por_low_in
	|-> ##[1:5] (!reset_output_n && (mode_state == 3'h3 || mode_state == 3'h4)))
	else $error("no reset on mcu low");
AST_WD_RST: assert property (mode_state == 3'h2 && !wd_active && $rose(wd_trigger_in)
	|-> ##[1:5] (wd_active && wd_long_window)) else $error("no wd restart");
AST_WAKE: assert property ($rose(can_wake_in) && mode_state == 3'h2 |-> ##[1:5] wake_irq)
	else $error("no wake pulse");
AST_RXD: assert property ($rose(can_wake_in) && mode_state == 3'h2 |-> ##[1:5] can_rxd_low)
	else $error("rxd not low");
AST_POR: assert property ($rose(vs_por_low_in) ##1 vs_por_low_in [*3]
	|=> mode_state == 3'h0 && !reset_output_n) else $error("no init on main loss");
AST_SCP: assert property (vs_low_in [*4] |=> !sc_prot_on) else $error("short prot on");
endmodule
bind sssw_supervisor sssw_props u_props (.*);
`default_nettype wire

// ==== sssw_mcu_model.sv ====
// microcontroller side: apb master, one transfer per call
// assumes the supervisor clock; a call starts at the next edge
`timescale 1ns/1ps
`default_nettype none
module sssw_mcu_model (
	input wire logic clk, // clock
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	output logic psel, // select
	output logic penable, // enable
	output logic pwrite, // direction
	output logic [11:0] paddr, // address
	output logic [31:0] pwdata // write data
);
initial {psel, penable, pwrite, paddr, pwdata} = '0;
// released address and data get inverted so stale values never look valid
task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
	output logic [31:0] q, output logic e);
	@(posedge clk);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge clk);
	penable <= 1'b1;
	do @(posedge clk); while (pready !== 1'b1);
	q = prdata;
	e = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
	paddr <= ~a;
	pwdata <= ~d;
endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// bench for the supervisor: apb traffic through the mcu model, supply stimulus
// assumes short count parameters and a 20 mhz clock
`timescale 1ns/1ps
`default_nettype none
`include "sssw_defs.vh"
module tb;
localparam logic [11:0] MD = `SSSW_OFF_MODE, WC = `SSSW_OFF_WDCTRL, WK = `SSSW_OFF_WAKE;
localparam logic [11:0] FL = `SSSW_OFF_FLAGS, CF = `SSSW_OFF_CFG, ST = `SSSW_OFF_STAT;
logic clk = 0, rst = 1;
logic vs_low_in, vs_por_low_in, sw_low_in, sw_high_in, mcu_warn_in, mcu_low_in, mcu_high_in;
logic v2_low_in, v2_ramp_in, can_low_in, can_wake_in, wd_trigger_in, wd_seq_err_in;
logic fail_config_select, e;
wire psel, penable, pwrite, pready, pslverr, reset_output_n, fail_outputs, mcu_supply_on;
wire aux_reg_on, sc_prot_on, wake_irq, can_rxd_low, wd_active, wd_long_window;
wire [11:0] paddr;
wire [31:0] pwdata, prdata;
wire [2:0] mode_state;
int n_mismatch = 0, samples_checked = 0, cyc_n = 0, i;
logic [31:0] seed = 32'ha530, m_fl, q;
always #25 clk = ~clk;
sssw_supervisor #(.RD_CYCLES(20), .SC_CYCLES(30), .LW_CYCLES(50)) u_dut (.*);
sssw_mcu_model u_mcu (.*);
task end_sim;
	$display("compared %0d mismatched %0d", samples_checked, n_mismatch);
	if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
	else $display("Test failed");
	$finish;
endtask
task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
	samples_checked++;
	if (seen !== exp) begin
		n_mismatch++;
		$display("BAD %s expected %h seen %h", nm, exp, seen);
	end
endtask
task rd(input logic [11:0] a, input logic [31:0] exp);
	u_mcu.xfer(1'b0, a, '0, q, e);
	chk("register", q, exp);
endtask
task wr(input logic [11:0] a, input logic [31:0] d);
	u_mcu.xfer(1'b1, a, d, q, e);
endtask
task cyc(input int n);
	repeat (n) @(posedge clk);
endtask
// bounded waits: a hang shows up as a mismatch, not a stall
task wmode(input logic [2:0] m);
	int k;
	k = 0;
	while ((mode_state !== m || reset_output_n !== 1'b1) && m != 3'h0 && k < 300) begin
		@(posedge clk);
		k++;
	end
	chk("mode", mode_state, m);
endtask
function logic [31:0] xs(input logic [31:0] s);
	s ^= s << 13;
	s ^= s >> 17;
	s ^= s << 5;
	return s;
endfunction
always @(posedge clk) begin
	cyc_n++;
	if (cyc_n > 20000) begin
		n_mismatch++;
		end_sim;
	end
end
initial begin
	{vs_low_in, vs_por_low_in, sw_low_in, sw_high_in, mcu_warn_in, mcu_low_in} = '0;
	{mcu_high_in, v2_low_in, v2_ramp_in, can_low_in, can_wake_in} = '0;
	{wd_trigger_in, wd_seq_err_in, fail_config_select} = '0;
	repeat (3) @(posedge clk);
	rst <= 1'b0;
	rd(FL, 32'h1);
	rd(WK, 32'h2);
	rd(WC, 32'h0);
	rd(CF, 32'h0);
	u_mcu.xfer(1'b0, 12'h020, '0, q, e);
	chk("slverr", e, 1'b1);
	wr(MD, `SSSW_CMD_NORMAL);
	wmode(3'h1);
	wr(FL, 32'h7ff);
	rd(FL, 32'h0);
	$display("test defaults done");
	for (i = 0; i < 3; i++) begin
		seed = xs(seed);
		{can_low_in, v2_low_in, mcu_warn_in, sw_high_in, sw_low_in, vs_low_in} <= seed[5:0] | 6'h1;
		m_fl = {seed[5:4], 4'h0, seed[3:1], 1'b1, 1'b0};
		cyc(6);
		rd(FL, m_fl);
		chk("mode", mode_state, 3'h1);
		chk("aux off", aux_reg_on, 1'b0);
		{can_low_in, v2_low_in, mcu_warn_in} <= '0;
		cyc(6);
		wr(FL, 32'h7ff);
		rd(FL, m_fl & 32'he);
		{sw_high_in, sw_low_in, vs_low_in} <= '0;
		cyc(6);
		wr(FL, 32'h7ff);
		rd(FL, 32'h0);
	end
	$display("test flags done");
	wr(WK, 32'h3);
	wr(WC, 32'h10);
	rd(WK, 32'h2);
	wd_seq_err_in <= 1'b1;
	cyc(2);
	wd_seq_err_in <= 1'b0;
	cyc(5);
	rd(WC, 32'h0);
	wr(WC, 32'h10);
	wr(WK, 32'h3);
	rd(WC, 32'h10);
	wr(MD, `SSSW_CMD_STOP);
	wmode(3'h2);
	cyc(2);
	chk("wd off", wd_active, 1'b0);
	wd_trigger_in <= 1'b1;
	cyc(5);
	chk("wd restart", {wd_active, wd_long_window}, 2'h3);
	wd_trigger_in <= 1'b0;
	rd(WC, 32'h0);
	rd(WK, 32'h2);
	cyc(60);
	chk("long window end", wd_long_window, 1'b0);
	can_wake_in <= 1'b1;
	cyc(5);
	chk("rxd low", can_rxd_low, 1'b1);
	can_wake_in <= 1'b0;
	wr(MD, `SSSW_CMD_NORMAL);
	wmode(3'h1);
	wr(WC, 32'h10);
	wr(WK, 32'h3);
	rd(WK, 32'h3);
	rd(WC, 32'h10);
	$display("test stop watchdog done");
	wr(CF, 32'h1);
	wr(MD, `SSSW_CMD_SOFTRST);
	cyc(5);
	wmode(3'h0);
	rd(CF, 32'h0);
	wr(MD, `SSSW_CMD_NORMAL);
	wmode(3'h1);
	$display("test soft reset done");
	for (i = 0; i < 4; i++) begin
		mcu_low_in <= 1'b1;
		cyc(6);
		chk("uv mode", mode_state, i < 3 ? 3'h3 : 3'h4);
		mcu_low_in <= 1'b0;
		if (i < 3) begin
			wmode(3'h1);
			rd(ST, i + 1);
		end
	end
	rd(FL, 32'h60);
	rd(ST, 32'h0);
	$display("test undervoltage count done");
	vs_por_low_in <= 1'b1;
	cyc(6);
	chk("por mode", mode_state, 3'h0);
	vs_por_low_in <= 1'b0;
	cyc(4);
	rd(FL, 32'h1);
	$display("test main supply loss done");
	wr(CF, 32'h2);
	mcu_high_in <= 1'b1;
	cyc(6);
	chk("ov mode", mode_state, 3'h4);
	chk("fail out", fail_outputs, 1'b1);
	mcu_high_in <= 1'b0;
	rd(FL, 32'h81);
	$display("test overvoltage done");
	end_sim;
end
endmodule
`default_nettype wire
